// *** rtl/itx_ctx_ctrl.sv ***
// control and status core of eight isochronous transmit contexts
//
// Summary of operation
// - armed context sends first packet on target cycle
// - target is two seconds bits plus cycle number
// - armed context starts only on timer match
// - hardware clears arm once context is active
// - descriptor fetch may start before target cycle
// - run changes only by software or reset
// - software sets wake, a fetch clears it unless wake is set in the same cycle
// - fatal error sets dead, run clear clears
// - active shows processing, resets to zero
// - reserved bits 14:13 and 9:8 read zero
// - speed field carries nothing for transmit
// - completion code stored after last output command
// - eight contexts, set at 200h+16n, clear +4
// - up to seven skipped cycles tolerated
`timescale 1ns/100ps
module itx_ctx_ctrl (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     soft_reset_i,
   input  wire logic [11:0]              addr_i,
   input  wire logic [31:0]              wdata_i,
   input  wire logic                     wr_i,
   input  wire logic                     rd_i,
   output      logic [31:0]              rdata_o,
   input  wire logic [31:0]              cycle_timer_i,
   input  wire logic                     cycle_start_i,
   input  wire logic [7:0]               fetch_i,
   input  wire logic [7:0]               idle_i,
   input  wire logic [7:0]               fatal_i,
   input  wire logic [7:0]               overflow_i,
   input  wire logic                     cmpl_valid_i,
   output      logic                     cmpl_ready_o,
   input  wire logic [7:0]               cmpl_data_i,
   output      logic [7:0]               run_o,
   output      logic [7:0]               fetch_en_o,
   output      logic [7:0]               tx_en_o,
   output      logic [7:0]               wake_o,
   output      logic [7:0]               dead_o,
   output      logic                     fatal_error_event_o
);
   `include "itx_regs.svh"

   // ----------------------------------------------------------------------
   // decode and packing helpers
   // ----------------------------------------------------------------------
   // which register of the block an address names
   function automatic itx_pkg::itx_acc_t acc_decode(
      input logic [11:0] a
   );
      itx_pkg::itx_acc_t r;
      r = itx_pkg::ITX_ACC_NONE;
      if (a[11:7] == `ITX_BLOCK_SEL && a[1:0] == 2'h0) begin
         if (a[3:2] == `ITX_SET_SUB) begin
            r = itx_pkg::ITX_ACC_SET;
         end else if (a[3:2] == `ITX_CLR_SUB) begin
            r = itx_pkg::ITX_ACC_CLR;
         end
      end
      return r;
   endfunction : acc_decode

   // control word as software sees it
   function automatic logic [31:0] pack_ctrl(input itx_pkg::itx_ctx_t c);
      logic [31:0] w;
      w = `ITX_CTRL_RESET;  // reserved and speed bits stay zero
      w[`ITX_ARM_BIT]              = c.arm;
      w[`ITX_TGT_HI:`ITX_TGT_LO]   = c.target;
      w[`ITX_RUN_BIT]              = c.run;
      w[`ITX_WAKE_BIT]             = c.wake;
      w[`ITX_DEAD_BIT]             = c.dead;
      w[`ITX_ACT_BIT]              = c.active;
      w[4:0]                       = c.code;
      return w;
   endfunction : pack_ctrl

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   itx_pkg::itx_ctx_t ctx_q    [`ITX_NUM_CTX];  // context state
   itx_pkg::itx_ctx_t next_ctx [`ITX_NUM_CTX];
   logic [2:0]        skip_q   [`ITX_NUM_CTX];  // consecutive skips
   logic [2:0]        next_skip[`ITX_NUM_CTX];
   logic [31:0]       next_rdata;               // read answer
   logic              next_fatal_evt;           // skip limit pulse
   itx_pkg::itx_acc_t wr_acc;                   // write decode
   itx_pkg::itx_acc_t rd_acc;                   // read decode
   logic [2:0]        sel;                      // context index
   logic [7:0]        match;                    // timer equals target
   logic [119:0]      targets;                  // targets, packed
   logic              drain_fire;               // code taken from fifo
   logic [31:0]       rd_word;                  // word of addressed ctx

   itx_stream_if #(.WIDTH(`ITX_FIFO_WIDTH)) cmpl_q ();

   // ----------------------------------------------------------------------
   // completion buffer and comparators
   // ----------------------------------------------------------------------
   itx_fifo #(
      .WIDTH (`ITX_FIFO_WIDTH),
      .DEPTH (`ITX_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .clear_i    (soft_reset_i),
      .in_valid_i (cmpl_valid_i),
      .in_ready_o (cmpl_ready_o),
      .in_data_i  (cmpl_data_i),
      .out        (cmpl_q.src)
   );

   for (genvar n = 0; n < `ITX_NUM_CTX; n++) begin : g_tgt
      assign targets[n*15 +: 15] = ctx_q[n].target;
      assign run_o[n]      = ctx_q[n].run;
      assign fetch_en_o[n] = ctx_q[n].run && !ctx_q[n].dead;
      assign tx_en_o[n]    = ctx_q[n].active;
      assign wake_o[n]     = ctx_q[n].wake;
      assign dead_o[n]     = ctx_q[n].dead;
   end

   itx_cycle_match u_match (
      .cycle_timer_i (cycle_timer_i),
      .targets_i     (targets),
      .match_o       (match)
   );

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   assign wr_acc  = wr_i ? acc_decode(addr_i) : itx_pkg::ITX_ACC_NONE;
   assign rd_acc  = rd_i ? acc_decode(addr_i) : itx_pkg::ITX_ACC_NONE;
   assign sel     = addr_i[6:4];
   assign rd_word = pack_ctrl(ctx_q[sel]);
   // codes are not taken while software writes, which keeps the update
   // order simple at the cost of buffer drain in every cycle with wr_i high
   assign cmpl_q.ready = !wr_i;
   assign drain_fire   = cmpl_q.valid && cmpl_q.ready;

   // ----------------------------------------------------------------------
   // context next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [31:0] set_m;
      logic [31:0] clr_m;
      logic        run_fall;
      logic        skip_fatal;
      logic        go;
      set_m          = `ITX_CTRL_RESET;
      clr_m          = `ITX_CTRL_RESET;
      run_fall       = 1'b0;
      skip_fatal     = 1'b0;
      go             = 1'b0;
      next_fatal_evt = 1'b0;
      for (int n = 0; n < `ITX_NUM_CTX; n++) begin
         next_ctx[n]  = ctx_q[n];
         next_skip[n] = skip_q[n];
         // strobed masks for this context only
         set_m = (wr_acc == itx_pkg::ITX_ACC_SET && sel == 3'(n)) ?
                 wdata_i : `ITX_CTRL_RESET;
         clr_m = (wr_acc == itx_pkg::ITX_ACC_CLR && sel == 3'(n)) ?
                 wdata_i : `ITX_CTRL_RESET;
         // run and target: software only
         next_ctx[n].run = (ctx_q[n].run | set_m[`ITX_RUN_BIT]) &
                           ~clr_m[`ITX_RUN_BIT];
         next_ctx[n].target = (ctx_q[n].target |
                               set_m[`ITX_TGT_HI:`ITX_TGT_LO]) &
                              ~clr_m[`ITX_TGT_HI:`ITX_TGT_LO];
         run_fall = ctx_q[n].run && !next_ctx[n].run;
         // arm: a software set beats the hardware clear
         next_ctx[n].arm = set_m[`ITX_ARM_BIT] |
                           (ctx_q[n].arm & ~clr_m[`ITX_ARM_BIT] &
                            ~ctx_q[n].active);
         // wake: set beats the clear from a fetch
         next_ctx[n].wake = set_m[`ITX_WAKE_BIT] |
                            (ctx_q[n].wake & ~fetch_i[n]);
         // skip counting; a clean cycle start restarts the count
         skip_fatal = 1'b0;
         if (overflow_i[n] && ctx_q[n].run && !ctx_q[n].dead) begin
            if (skip_q[n] == `ITX_MAX_SKIPS) begin
               skip_fatal   = 1'b1;
               next_skip[n] = 3'h0;
            end else begin
               next_skip[n] = skip_q[n] + 3'h1;
            end
         end else if (cycle_start_i || !ctx_q[n].run) begin
            next_skip[n] = 3'h0;
         end
         // dead: a new fault wins over the run clear
         next_ctx[n].dead = fatal_i[n] | skip_fatal |
                            (ctx_q[n].dead & ~run_fall);
         // active: armed contexts wait for the timer to match
         go = ctx_q[n].run && !ctx_q[n].dead && !idle_i[n] &&
              (ctx_q[n].active || !ctx_q[n].arm || match[n]);
         next_ctx[n].active = go && next_ctx[n].run &&
                              !next_ctx[n].dead;
         // completion code from the buffer, timeout overrides it
         if (drain_fire && cmpl_q.data[7:5] == 3'(n)) begin
            next_ctx[n].code = cmpl_q.data[4:0];
         end
         if (skip_fatal) begin
            next_ctx[n].code = `ITX_EVT_TIMEOUT;
            next_fatal_evt   = 1'b1;
         end
         if (soft_reset_i) begin
            next_ctx[n]  = '0;
            next_skip[n] = 3'h0;
         end
      end
      if (soft_reset_i) begin
         next_fatal_evt = 1'b0;
      end
   end

   // read answer: only in the cycle after the strobe, zero otherwise
   always_comb begin
      next_rdata = `ITX_CTRL_RESET;
      if (rd_acc != itx_pkg::ITX_ACC_NONE) begin
         next_rdata = rd_word;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int n = 0; n < `ITX_NUM_CTX; n++) begin
            ctx_q[n]  <= '0;
            skip_q[n] <= 3'h0;
         end
         rdata_o             <= `ITX_CTRL_RESET;
         fatal_error_event_o <= 1'b0;
      end else begin
         for (int n = 0; n < `ITX_NUM_CTX; n++) begin
            ctx_q[n]  <= next_ctx[n];
            skip_q[n] <= next_skip[n];
         end
         rdata_o             <= next_rdata;
         fatal_error_event_o <= next_fatal_evt;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   for (genvar n = 0; n < `ITX_NUM_CTX; n++) begin : g_chk
      arm_auto_clear_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         ctx_q[n].active && !soft_reset_i &&
         !(wr_acc == itx_pkg::ITX_ACC_SET && sel == 3'(n) &&
           wdata_i[`ITX_ARM_BIT]) |=> !ctx_q[n].arm)
         else $error("arm not cleared after active");

      start_on_match_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         $rose(ctx_q[n].active) |->
            $past(!ctx_q[n].arm || match[n]))
         else $error("armed context started off target cycle");

      run_sw_only_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         $changed(ctx_q[n].run) |->
            $past(soft_reset_i || (wr_i && sel == 3'(n))))
         else $error("run changed without software");

      wake_fetch_clr_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         fetch_i[n] && !(wr_acc == itx_pkg::ITX_ACC_SET &&
                         sel == 3'(n) && wdata_i[`ITX_WAKE_BIT])
         |=> !ctx_q[n].wake)
         else $error("wake survived a fetch");

      dead_run_clr_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         ctx_q[n].run && wr_acc == itx_pkg::ITX_ACC_CLR &&
         sel == 3'(n) && wdata_i[`ITX_RUN_BIT] && !fatal_i[n]
         |=> !ctx_q[n].dead && !ctx_q[n].run ##1 !ctx_q[n].active)
         else $error("run clear left dead or active set");

      fatal_sets_dead_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         fatal_i[n] && !soft_reset_i |=> ctx_q[n].dead && !tx_en_o[n])
         else $error("fatal error did not kill context");

      skip_limit_a : assert property (
         @(posedge ref_clk_i) disable iff (!rst_n_i)
         overflow_i[n] && ctx_q[n].run && !ctx_q[n].dead &&
         skip_q[n] == `ITX_MAX_SKIPS && !soft_reset_i
         |=> ctx_q[n].dead && ctx_q[n].code == `ITX_EVT_TIMEOUT &&
             fatal_error_event_o)
         else $error("eighth skip not fatal");
   end

   code_capture_a : assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      drain_fire && !soft_reset_i && !overflow_i[cmpl_q.data[7:5]]
      |=> ctx_q[$past(cmpl_q.data[7:5])].code == $past(cmpl_q.data[4:0]))
      else $error("completion code not stored");

   read_word_a : assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_acc != itx_pkg::ITX_ACC_NONE |=>
         rdata_o == $past(rd_word) && rdata_o[14:13] == 2'h0 &&
         rdata_o[9:5] == 5'h00)
      else $error("read answer wrong");

   read_idle_a : assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !rd_i |=> rdata_o == `ITX_CTRL_RESET)
      else $error("read data outside answer cycle");

endmodule : itx_ctx_ctrl

// *** rtl/itx_cycle_match.sv ***
// per-context comparison of the cycle timer against the target cycle
`timescale 1ns/100ps
`include "itx_regs.svh"
module itx_cycle_match (
   input  wire logic [31:0]                  cycle_timer_i,
   input  wire logic [`ITX_NUM_CTX*15-1:0]   targets_i,
   output      logic [`ITX_NUM_CTX-1:0]      match_o
);
   logic [14:0] now_cycle;  // low seconds bits and cycle number

   // ----------------------------------------------------------------------
   // compare
   // ----------------------------------------------------------------------
   assign now_cycle = cycle_timer_i[`ITX_TMR_HI:`ITX_TMR_LO];

   // one comparator per context
   for (genvar n = 0; n < `ITX_NUM_CTX; n++) begin : g_cmp
      assign match_o[n] = (targets_i[n*15 +: 15] == now_cycle);
   end

endmodule : itx_cycle_match

// *** rtl/itx_fifo.sv ***
// flip-flop fifo holding completion reports from the link side
`timescale 1ns/100ps
module itx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clear_i,
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   itx_stream_if.src             out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW:0]      wr_ptr;       // write pointer with wrap bit
   logic [AW:0]      rd_ptr;       // read pointer with wrap bit
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             full;
   logic             empty;

   // ----------------------------------------------------------------------
   // flags and handshakes
   // ----------------------------------------------------------------------
   assign empty      = (wr_ptr == rd_ptr);
   assign full       = (wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready_o = !full;
   assign out.valid  = !empty;
   assign out.data   = mem[rd_ptr[AW-1:0]];

   // pointer next values; clear drops everything queued
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (in_valid_i && !full) begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (out.ready && !empty) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
      if (clear_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
      end
   end

   // pointer registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage needs no reset: a word is only read after being written
   always_ff @(posedge ref_clk_i) begin
      if (in_valid_i && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   // a full fifo never advances its write pointer
   fifo_no_over_a : assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      full && !out.ready && !clear_i |=> $stable(wr_ptr))
      else $error("fifo pointer moved while full");

endmodule : itx_fifo

// *** rtl/itx_pkg.sv ***
// types shared by the transmit context control files
package itx_pkg;

   // ----------------------------------------------------------------------
   // one context's control state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        arm;     // cycle_match_arm
      logic [14:0] target;  // target_cycle_value
      logic        run;     // processing enabled by software
      logic        wake;    // resume request
      logic        dead;    // fatal error seen
      logic        active;  // processing descriptors
      logic [4:0]  code;    // completion code
   } itx_ctx_t;

   // register access decode
   typedef enum logic [1:0] {
      ITX_ACC_NONE = 2'h0,
      ITX_ACC_SET  = 2'h1,
      ITX_ACC_CLR  = 2'h2
   } itx_acc_t;

endpackage : itx_pkg

// *** rtl/itx_regs.svh ***
// register offsets, field positions, reset values and codes of the block
`ifndef ITX_REGS_SVH
`define ITX_REGS_SVH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define ITX_NUM_CTX      8
`define ITX_ADDR_W       12
`define ITX_SET_OFFSET   12'h200
`define ITX_CLR_OFFSET   12'h204
`define ITX_CTX_STRIDE   12'h010
`define ITX_BLOCK_SEL    5'h04
`define ITX_SET_SUB      2'h0
`define ITX_CLR_SUB      2'h1

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define ITX_ARM_BIT      31
`define ITX_TGT_HI       30
`define ITX_TGT_LO       16
`define ITX_RUN_BIT      15
`define ITX_WAKE_BIT     12
`define ITX_DEAD_BIT     11
`define ITX_ACT_BIT      10
`define ITX_CTRL_RESET   32'h00000000

// ----------------------------------------------------------------------
// cycle timer fields: two low seconds bits then the cycle number
// ----------------------------------------------------------------------
`define ITX_TMR_HI       26
`define ITX_TMR_LO       12

// ----------------------------------------------------------------------
// completion codes and skip tolerance
// ----------------------------------------------------------------------
`define ITX_EVT_ACK_COMPLETE  5'h01
`define ITX_EVT_DESC_READ     5'h02
`define ITX_EVT_DATA_READ     5'h03
`define ITX_EVT_TIMEOUT       5'h04
`define ITX_EVT_UNKNOWN       5'h1F
`define ITX_MAX_SKIPS         3'h7
`define ITX_FIFO_DEPTH        32
`define ITX_FIFO_WIDTH        8

`endif

// *** rtl/itx_stream_if.sv ***
// valid/ready carrier between the completion buffer and the control core
`timescale 1ns/100ps
interface itx_stream_if #(parameter int WIDTH = 8);
   logic             valid;  // word present
   logic             ready;  // consumer takes it
   logic [WIDTH-1:0] data;   // word
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : itx_stream_if

// *** sim/itx_ctx_ctrl_tb.sv ***
// self-checking bench of the transmit context control core
`timescale 1ns/100ps
module itx_ctx_ctrl_tb;
   logic        ref_clk_i = 1'b0;     // 25 MHz clock
   logic        rst_n_i = 1'b0;       // async reset, active low
   logic        soft_reset_i = 1'b0;  // software reset
   logic [11:0] addr_i = 12'h000;     // register address
   logic [31:0] wdata_i = 32'h00000000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [31:0] cycle_timer_i = 32'h00000000;
   logic        cycle_start_i = 1'b0;
   logic [7:0]  fetch_i = 8'h00;
   logic [7:0]  idle_i = 8'h00;
   logic [7:0]  fatal_i = 8'h00;
   logic [7:0]  overflow_i = 8'h00;
   logic        cmpl_valid_i;
   logic        cmpl_ready_o;
   logic [7:0]  cmpl_data_i;
   logic [7:0]  run_o, fetch_en_o, tx_en_o, wake_o, dead_o;
   logic        fatal_error_event_o;
   int          num_errors = 0;
   int          n_tests = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   itx_ctx_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .soft_reset_i(soft_reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .cycle_timer_i(cycle_timer_i), .cycle_start_i(cycle_start_i),
      .fetch_i(fetch_i), .idle_i(idle_i), .fatal_i(fatal_i),
      .overflow_i(overflow_i), .cmpl_valid_i(cmpl_valid_i),
      .cmpl_ready_o(cmpl_ready_o), .cmpl_data_i(cmpl_data_i),
      .run_o(run_o), .fetch_en_o(fetch_en_o), .tx_en_o(tx_en_o),
      .wake_o(wake_o), .dead_o(dead_o),
      .fatal_error_event_o(fatal_error_event_o));

   itx_link_model lnk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .ready_i(cmpl_ready_o), .valid_o(cmpl_valid_i), .data_o(cmpl_data_i));

   // ----------------------------------------------------------------------
   // shared bus and compare tasks
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string w, input logic [11:0] a, logic [31:0] e);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      check(w, rdata_o, e);
   endtask : rd_chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_regs;
      for (int n = 0; n < 8; n++) begin
         rd_chk("reset word", 12'h200 + 12'(16 * n), 32'h00000000);
         wr(12'h200 + 12'(16 * n), 32'hFFFFFFFF);
         rd_chk("set word", 12'h204 + 12'(16 * n), 32'hFFFF9000);
      end
      check("run all", run_o, 8'hFF);
      for (int n = 0; n < 8; n++) begin
         wr(12'h204 + 12'(16 * n), 32'hFFFFFFFF);
         rd_chk("clr word", 12'h200 + 12'(16 * n), 32'h00001000);
      end
      check("run none", run_o, 8'h00);
      @(posedge ref_clk_i);
      fetch_i <= 8'hFF;
      @(posedge ref_clk_i);
      fetch_i <= 8'h00;
      @(negedge ref_clk_i);
      check("wake fetch", wake_o, 8'h00);
      rd_chk("unmapped", 12'h208, 32'h00000000);
      wr(12'h20C, 32'hFFFFFFFF);
      rd_chk("unmapped wr", 12'h200, 32'h00000000);
   endtask : t_regs

   task automatic t_arm;
      wr(12'h210, 32'h80008000 | (32'h1234 << 16));
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("wait match", tx_en_o[1], 1'b0);
      check("work ahead", fetch_en_o[1], 1'b1);
      // context 1 still holds the descriptor read code from the buffer test
      rd_chk("armed", 12'h214, 32'h92348002);
      @(posedge ref_clk_i);
      cycle_timer_i <= {5'h00, 15'h1234, 12'h000};
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("tx on match", tx_en_o[1], 1'b1);
      rd_chk("arm cleared", 12'h210, 32'h12348402);
      wr(12'h214, 32'hFFFFFFFF);
   endtask : t_arm

   task automatic t_dead;
      wr(12'h230, 32'h00008000);
      @(posedge ref_clk_i);
      fatal_i <= 8'h08;
      @(posedge ref_clk_i);
      fatal_i <= 8'h00;
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("dead set", {dead_o[3], fetch_en_o[3], tx_en_o[3]}, 3'h4);
      // context 3 keeps the unknown-event code left by the buffer test
      rd_chk("dead word", 12'h234, 32'h0000881F);
      wr(12'h234, 32'h00008000);
      @(negedge ref_clk_i);
      check("dead clr", dead_o[3], 1'b0);
   endtask : t_dead

   // wr_i held high stops the drain, so the buffer fills up and the link stalls
   task automatic t_cmpl;
      int full;
      logic [4:0] codes[4];
      full = 0;
      codes = '{5'h01, 5'h02, 5'h03, 5'h1F};
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= 12'h208;
      wdata_i <= 32'h00000000;
      for (int i = 0; i < 34; i++)
         lnk.push({3'(i % 4), codes[i % 4]});
      repeat (45) begin
         @(negedge ref_clk_i);
         if (cmpl_ready_o === 1'b0)
            full++;
      end
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      check("fifo full", 32'(full > 0), 32'h1);
      repeat (50) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("fifo empty", {cmpl_ready_o, cmpl_valid_i}, 2'h2);
      for (int n = 0; n < 4; n++)
         rd_chk("code", 12'h200 + 12'(16 * n), 32'(codes[n]));
   endtask : t_cmpl

   task automatic t_skip;
      wr(12'h240, 32'h00008000);
      // one skip, then a clean cycle start must restart the count
      @(posedge ref_clk_i);
      overflow_i <= 8'h10;
      @(posedge ref_clk_i);
      overflow_i <= 8'h00;
      cycle_start_i <= 1'b1;
      @(posedge ref_clk_i);
      cycle_start_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk_i);
         if (i == 7)
            check("seven skips", dead_o[4], 1'b0);
         @(posedge ref_clk_i);
         overflow_i <= 8'h10;
         @(posedge ref_clk_i);
         overflow_i <= 8'h00;
      end
      @(negedge ref_clk_i);
      check("skip event", {fatal_error_event_o, dead_o[4]}, 2'h3);
      rd_chk("timeout", 12'h244, 32'h00008804);
      @(posedge ref_clk_i);
      soft_reset_i <= 1'b1;
      @(posedge ref_clk_i);
      soft_reset_i <= 1'b0;
      rd_chk("soft reset", 12'h240, 32'h00000000);
   endtask : t_skip

   // ----------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_cmpl();
      t_arm();
      t_dead();
      t_skip();
      end_sim();
   end

   // the run needs well under a thousand cycles; allow twenty times that
   initial begin
      #(40 * 20000);
      num_errors++;
      end_sim();
   end
endmodule : itx_ctx_ctrl_tb

// *** sim/itx_link_model.sv ***
// link side model that queues completion reports toward the block
`timescale 1ns/100ps
module itx_link_model (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ready_i,
   output      logic       valid_o,
   output      logic [7:0] data_o
);
   logic [7:0] q[$];  // reports waiting to be offered

   // ----------------------------------------------------------------------
   // queue access for the bench
   // ----------------------------------------------------------------------
   task automatic push(input logic [7:0] d);
      q.push_back(d);
   endtask : push

   // offer held until taken; idle data toggles so stale words never match
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         data_o  <= 8'h00;
      end else if (!valid_o || ready_i) begin
         if (q.size() > 0) begin
            data_o  <= q.pop_front();
            valid_o <= 1'b1;
         end else begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
         end
      end
   end
endmodule : itx_link_model
